//--- core_model.sv
`timescale 1ns/1ps
`default_nettype none

module core_model (
	input  wire logic        clk,
	input  wire logic        start,
	input  wire logic [15:0] value,
	input  wire logic [15:0] dly,
	output logic             done,
	output logic [15:0]      data
);
	// answers each start after dly cycles; data is junk outside the done pulse
	initial begin
		done = 1'b0;
		data = 16'hffff;
		forever begin
			@(negedge clk);
			if (start) begin
				repeat (dly) @(posedge clk);
				done <= 1'b1;
				data <= value;
				@(posedge clk);
				done <= 1'b0;
				data <= ~value;
			end
		end
	end
endmodule

`default_nettype wire

//--- sar_host_if.sv
`timescale 1ns/1ps
`default_nettype none

module sar_host_if (
	input  wire logic        REF_CLK,
	input  wire logic        RST,
	input  wire logic        CS_N,
	input  wire logic        READ_CONVERT_N,
	input  wire logic        BYTE_SELECT,
	input  wire logic        OUTPUT_FORMAT_SELECT,
	input  wire logic        SERIAL_CLOCK_SOURCE_SELECT,
	input  wire logic        SERIAL_BIT_CLOCK_I,
	output logic             SERIAL_BIT_CLOCK_O,
	output logic             SERIAL_BIT_CLOCK_OE,
	output logic             SERIAL_RESULT_OUT,
	input  wire logic        CHAIN_IN,
	output logic [7:0]       PARALLEL_OUT,
	output logic             PARALLEL_OE,
	output logic             BUSY_N,
	output logic             CONV_START,
	input  wire logic        CONV_DONE,
	input  wire logic [15:0] CONV_DATA,
	input  wire logic        ANALOG_POWER_DOWN,
	input  wire logic        INTERNAL_REF_DISABLE,
	output logic             ANALOG_ENABLE,
	output logic             INTERNAL_REF_ENABLE
);

	typedef enum logic {ST_IDLE, ST_CONV} phase_t;

	typedef struct packed {
		phase_t      phase;
		logic        conv_done;
		logic        ser_run;
		logic [3:0]  bit_cnt;
		logic [2:0]  div_cnt;
		logic        sclk;
		logic        sclk_oe;
		logic        ext_clk_d;
		logic [15:0] shreg;
		logic [15:0] result;
		logic        busy_n;
		logic        start;
		logic [7:0]  par;
		logic        par_oe;
		logic        ana_en;
		logic        ref_en;
	} state_t;

	localparam state_t STATE_RST = '{
		phase: ST_IDLE, conv_done: 1'b0, ser_run: 1'b0, bit_cnt: 4'h0, div_cnt: 3'h0,
		sclk: 1'b0, sclk_oe: 1'b0, ext_clk_d: 1'b0, shreg: sar_if_pkg::RESULT_RST,
		result: sar_if_pkg::RESULT_RST, busy_n: 1'b1, start: 1'b0, par: 8'h00,
		par_oe: 1'b0, ana_en: 1'b0, ref_en: 1'b0};

	localparam logic [2:0] HALF_LAST = 3'(sar_if_pkg::SCLK_HALF_CYC - 1);
	localparam logic [3:0] BIT_LAST  = 4'(sar_if_pkg::SER_BITS - 1);

	state_t r;
	state_t n;
	logic [sar_if_pkg::SYNC_W-1:0] sx;
	logic        cs_s;
	logic        rc_s;
	logic        byte_s;
	logic        fmt_s;
	logic        clksel_s;
	logic        chain_s;
	logic        cmd;
	logic        ext_fall;
	logic [15:0] fres;

	sync_bank #(
		.W       (sar_if_pkg::SYNC_W),
		.RST_VAL (sar_if_pkg::SYNC_RST)
	) u_sync (
		.clk (REF_CLK),
		.rst (RST),
		.d   ({CS_N, READ_CONVERT_N, BYTE_SELECT, OUTPUT_FORMAT_SELECT,
		       SERIAL_CLOCK_SOURCE_SELECT, SERIAL_BIT_CLOCK_I, CHAIN_IN,
		       ANALOG_POWER_DOWN, INTERNAL_REF_DISABLE}),
		.q   (sx)
	);

	assign cs_s     = sx[sar_if_pkg::SX_CS_N];
	assign rc_s     = sx[sar_if_pkg::SX_RC_N];
	assign byte_s   = sx[sar_if_pkg::SX_BYTE];
	assign fmt_s    = sx[sar_if_pkg::SX_FMT];
	assign clksel_s = sx[sar_if_pkg::SX_CLKSEL];
	assign chain_s  = sx[sar_if_pkg::SX_CHAIN];
	assign cmd      = !(cs_s || rc_s);
	assign ext_fall = r.ext_clk_d && !sx[sar_if_pkg::SX_SCLK];
	// high selects straight binary, low flips the msb
	assign fres     = fmt_s ? r.result
	                        : {~r.result[sar_if_pkg::RESULT_MSB], r.result[14:0]};

	always_comb begin
		n           = r;
		n.start     = 1'b0;
		n.ext_clk_d = sx[sar_if_pkg::SX_SCLK];
		n.sclk_oe   = !clksel_s;
		n.ana_en    = !sx[sar_if_pkg::SX_ANALOG_POWER_DOWN];
		n.ref_en    = !sx[sar_if_pkg::SX_INTERNAL_REF_DISABLE];
		n.par_oe    = !cs_s && rc_s;
		n.par       = byte_s ? fres[sar_if_pkg::BYTE_W-1:0]
		                     : fres[sar_if_pkg::RESULT_MSB:sar_if_pkg::HI_BYTE_LSB];

		// internal serial clock divider
		if (r.ser_run) begin
			if (r.div_cnt == HALF_LAST) begin
				n.div_cnt = 3'h0;
				if (!r.sclk) begin
					n.sclk = 1'b1;
				end else begin
					n.sclk    = 1'b0;
					n.shreg   = {r.shreg[14:0], 1'b0};
					n.bit_cnt = r.bit_cnt + 4'h1;
					if (r.bit_cnt == BIT_LAST) begin
						n.ser_run = 1'b0;
					end
				end
			end else begin
				n.div_cnt = r.div_cnt + 3'h1;
			end
		end else if (clksel_s && ext_fall) begin
			n.shreg = {r.shreg[14:0], chain_s};
		end

		case (r.phase)
			ST_IDLE: begin
				if (cmd) begin
					n.phase     = ST_CONV;
					n.busy_n    = 1'b0;
					n.start     = 1'b1;
					n.conv_done = 1'b0;
					n.shreg     = fres;
					n.ser_run   = !clksel_s;
					n.bit_cnt   = 4'h0;
					n.div_cnt   = 3'h0;
					n.sclk      = 1'b0;
				end
			end
			ST_CONV: begin
				// new commands are ignored here
				if (CONV_DONE && !r.conv_done) begin
					n.result    = CONV_DATA;
					n.conv_done = 1'b1;
				end
				if (r.conv_done && !r.ser_run) begin
					n.phase  = ST_IDLE;
					n.busy_n = 1'b1;
				end
			end
			default: begin
				n.phase = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			r <= STATE_RST;
		end else begin
			r <= n;
		end
	end

	assign SERIAL_BIT_CLOCK_O  = r.sclk;
	assign SERIAL_BIT_CLOCK_OE = r.sclk_oe;
	assign SERIAL_RESULT_OUT   = r.shreg[sar_if_pkg::RESULT_MSB];
	assign PARALLEL_OUT        = r.par;
	assign PARALLEL_OE         = r.par_oe;
	assign BUSY_N              = r.busy_n;
	assign CONV_START          = r.start;
	assign ANALOG_ENABLE       = r.ana_en;
	assign INTERNAL_REF_ENABLE = r.ref_en;

	// rising serial clock edges per transfer
	logic [4:0] pulse_cnt;

	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			pulse_cnt <= 5'h00;
		end else if (r.start) begin
			pulse_cnt <= 5'h00;
		end else if (n.sclk && !r.sclk) begin
			pulse_cnt <= pulse_cnt + 5'h01;
		end
	end

	default clocking dc @(posedge REF_CLK); endclocking
	default disable iff (RST);

	sequence idle_cmd;
		r.phase == ST_IDLE && cmd;
	endsequence

	sequence int_start;
		idle_cmd and !clksel_s;
	endsequence

	par_hiz_a: assert property ((cs_s || !rc_s) |=> !PARALLEL_OE)
		else $error("data pins driven while deselected");
	par_drive_a: assert property ((!cs_s && rc_s) |=> PARALLEL_OE)
		else $error("data pins not driven on read");
	byte_lane_a: assert property (1'b1 |=> PARALLEL_OUT == ($past(byte_s) ? $past(fres[7:0])
		: $past(fres[15:8])))
		else $error("wrong byte on data pins");
	fmt_msb_a: assert property (!byte_s |=> PARALLEL_OUT[7] ==
		($past(fmt_s) ? $past(r.result[15]) : !$past(r.result[15])))
		else $error("wrong output coding");
	start_busy_a: assert property (idle_cmd |=> (CONV_START && !BUSY_N))
		else $error("conversion not started");
	or_start_a: assert property (($fell(cs_s) && !rc_s && r.phase == ST_IDLE) |=> CONV_START)
		else $error("select edge did not start");
	busy_ignore_a: assert property (!BUSY_N |=> !CONV_START)
		else $error("command accepted while busy");
	busy_rise_a: assert property ($rose(BUSY_N) |-> ($past(r.conv_done) && !r.ser_run))
		else $error("busy rose before results ready");
	result_hold_a: assert property (!(r.phase == ST_CONV && CONV_DONE) |=> $stable(r.result))
		else $error("result changed without conversion");
	ser_begin_a: assert property (int_start |=> (r.ser_run && r.shreg == $past(fres)))
		else $error("serial send not begun");
	ser_count_a: assert property ($fell(r.ser_run) |-> pulse_cnt == 5'h10)
		else $error("serial pulse count wrong");
	ser_sync_a: assert property (($changed(SERIAL_RESULT_OUT) && !CONV_START) |->
		($fell(SERIAL_BIT_CLOCK_O) || $past(ext_fall)))
		else $error("serial bit changed off clock");
	chain_in_a: assert property ((clksel_s && ext_fall && !r.ser_run
		&& !(r.phase == ST_IDLE && cmd)) |=>
		r.shreg[0] == $past(chain_s))
		else $error("chain bit not shifted in");
	clk_dir_a: assert property (1'b1 |=> SERIAL_BIT_CLOCK_OE == !$past(clksel_s))
		else $error("clock pin direction wrong");
	power_a: assert property (1'b1 |=> (ANALOG_ENABLE != $past(sx[sar_if_pkg::SX_ANALOG_POWER_DOWN])
		&& INTERNAL_REF_ENABLE != $past(sx[sar_if_pkg::SX_INTERNAL_REF_DISABLE])))
		else $error("power controls not followed");

endmodule

`default_nettype wire

//--- sar_if_pkg.sv
package sar_if_pkg;

	// clock and serial timing
	localparam int unsigned REF_CLK_NS    = 20;
	localparam int unsigned SCLK_HALF_NS  = 80;
	localparam int unsigned SCLK_HALF_CYC = (SCLK_HALF_NS + REF_CLK_NS - 1) / REF_CLK_NS;

	// result layout
	localparam int unsigned RESULT_W   = 16;
	localparam int unsigned BYTE_W     = 8;
	localparam int unsigned RESULT_MSB = 15;
	localparam int unsigned HI_BYTE_LSB = 8;
	localparam int unsigned SER_BITS   = 16;
	localparam logic [15:0] RESULT_RST = 16'h0000;

	// synchronised input vector layout
	localparam int unsigned SYNC_W       = 9;
	localparam int unsigned SX_CS_N      = 8;
	localparam int unsigned SX_RC_N      = 7;
	localparam int unsigned SX_BYTE      = 6;
	localparam int unsigned SX_FMT       = 5;
	localparam int unsigned SX_CLKSEL    = 4;
	localparam int unsigned SX_SCLK      = 3;
	localparam int unsigned SX_CHAIN     = 2;
	localparam int unsigned SX_ANALOG_POWER_DOWN      = 1;
	localparam int unsigned SX_INTERNAL_REF_DISABLE      = 0;
	localparam logic [8:0]  SYNC_RST     = 9'h180;

endpackage

//--- sync_bank.sv
`timescale 1ns/1ps
`default_nettype none

module sync_bank #(
	parameter int unsigned  W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] d,
	output var  logic [W-1:0] q
);

	logic [W-1:0] meta_r;

	// first stage feeds only the second stage
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_r <= RST_VAL;
			q      <= RST_VAL;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end

endmodule

`default_nettype wire

//--- test_sar_host_if.sv
`timescale 1ns/1ps
`default_nettype none

module test_sar_host_if;
	logic        clk, rst, cs_n, rc_n, bsel, fmt, ext, ck_i, chain, pd, internal_ref_disable, ck_d;
	logic        ck_o, ck_oe, sdo, poe, busy_n, start, done, aen, ren;
	logic [7:0]  pout;
	logic [15:0] cdata, val, prev, got, dly, expq[$];
	int          n_fail, n_tests, nbits, npulse, nstart, cyc;
	integer      seed = 32'hd247;

	sar_host_if sar_host_if_i (.REF_CLK(clk), .RST(rst), .CS_N(cs_n), .READ_CONVERT_N(rc_n),
		.BYTE_SELECT(bsel), .OUTPUT_FORMAT_SELECT(fmt), .SERIAL_CLOCK_SOURCE_SELECT(ext),
		.SERIAL_BIT_CLOCK_I(ck_i), .SERIAL_BIT_CLOCK_O(ck_o), .SERIAL_BIT_CLOCK_OE(ck_oe),
		.SERIAL_RESULT_OUT(sdo), .CHAIN_IN(chain), .PARALLEL_OUT(pout), .PARALLEL_OE(poe),
		.BUSY_N(busy_n), .CONV_START(start), .CONV_DONE(done), .CONV_DATA(cdata),
		.ANALOG_POWER_DOWN(pd), .INTERNAL_REF_DISABLE(internal_ref_disable), .ANALOG_ENABLE(aen),
		.INTERNAL_REF_ENABLE(ren));
	core_model core_model_i (.clk(clk), .start(start), .value(val), .dly(dly), .done(done),
		.data(cdata));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	function automatic logic [15:0] fx(input logic [15:0] v, input logic f);
		return f ? v : {~v[15], v[14:0]};
	endfunction

	task automatic final_report;
		if (n_fail == 0 && n_tests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	task automatic check(input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask

	// gathers serial bits and compares whole words with the oldest note
	task automatic take(input logic b);
		got = {got[14:0], b};
		nbits++;
		if (nbits == 16) begin
			nbits = 0;
			check(expq.size() > 0 ? expq.pop_front() : ~got, got);
		end
	endtask

	always @(negedge clk) begin
		ck_d <= ck_o;
		if (start) nstart++;
		if (ck_oe && ck_o && !ck_d) begin
			npulse++;
			take(sdo);
		end
		cyc++;
		if (cyc == 3000) begin
			n_fail++;
			final_report();
		end
	end

	always @(negedge ck_i) if (ext) take(sdo);

	task automatic convert(input logic f, input int d, input logic cs_last);
		int s;
		fmt = f;
		dly = 16'(d);
		val = 16'($random(seed));
		expq.push_back(fx(prev, f));
		repeat (4) @(negedge clk);
		s = nstart;
		npulse = 0;
		rc_n = 1'b0;
		if (cs_last) begin
			repeat (4) @(negedge clk);
			check({15'h0000, busy_n}, 16'h0001);
		end
		cs_n = 1'b0;
		repeat (3) @(negedge clk);
		check({14'h0000, busy_n, poe}, 16'h0000);
		check({15'h0000, ck_oe}, {15'h0000, ~ext});
		rc_n = 1'b1;
		repeat (5) @(negedge clk);
		rc_n = 1'b0;
		repeat (5) @(negedge clk);
		rc_n = 1'b1;
		for (int i = 0; i < 400 && busy_n !== 1'b1; i++) @(negedge clk);
		check(16'(nstart - s), 16'h0001);
		if (!ext) check(16'(npulse), 16'h0010);
		prev = val;
		for (int b = 0; b < 2; b++) begin
			bsel = b[0];
			repeat (4) @(negedge clk);
			check({7'h00, poe, pout}, {8'h01, 8'(b ? fx(val, f) : fx(val, f) >> 8)});
		end
		cs_n = 1'b1;
		repeat (4) @(negedge clk);
		check({15'h0000, poe}, 16'h0000);
	endtask

	initial begin
		{rst, cs_n, rc_n, bsel, fmt, ext, ck_i, chain, pd, internal_ref_disable} = 10'h380;
		val = 16'h0000;
		prev = 16'h0000;
		dly = 16'h001e;
		repeat (3) @(negedge clk);
		rst = 1'b0;
		for (int i = 0; i < 4; i++) begin
			{internal_ref_disable, pd} = i[1:0];
			repeat (4) @(negedge clk);
			check({14'h0000, ren, aen}, {14'h0000, ~i[1:0]});
		end
		{internal_ref_disable, pd} = 2'b01;
		convert(1'b1, 200, 1'b0);
		convert(1'b0, 30, 1'b1);
		ext = 1'b1;
		convert(1'b1, 30, 1'b0);
		val = 16'($random(seed));
		expq.push_back(val);
		for (int i = 0; i < 32; i++) begin
			ck_i = 1'b1;
			chain = i < 16 ? val[15 - i] : ~chain;
			#80 ck_i = 1'b0;
			#80;
		end
		repeat (4) @(negedge clk);
		check(16'(expq.size()), 16'h0000);
		final_report();
	end
endmodule

`default_nettype wire
